// >>> inc/tcc_pkg.sv
// shared constants and types for the timer channel in capture mode
package tcc_pkg;
    // register byte offsets
    localparam logic [7:0] TCC_OFS_CTRL = 8'h00;
    localparam logic [7:0] TCC_OFS_MODE = 8'h04;
    localparam logic [7:0] TCC_OFS_COUNT = 8'h10;
    localparam logic [7:0] TCC_OFS_CAP_A = 8'h14;
    localparam logic [7:0] TCC_OFS_CAP_B = 8'h18;
    localparam logic [7:0] TCC_OFS_CMP_C = 8'h1C;
    localparam logic [7:0] TCC_OFS_STATUS = 8'h20;
    localparam int TCC_AW = 8;
    // control command bit positions
    localparam int TCC_CMD_ON = 0;
    localparam int TCC_CMD_OFF = 1;
    localparam int TCC_CMD_TRIG = 2;
    // status bit positions
    localparam int TCC_ST_EN = 0;
    localparam int TCC_ST_RUN = 1;
    localparam int TCC_ST_LINE_A = 2;
    localparam int TCC_ST_LINE_B = 3;
    // mode register: writable bits and reset value
    localparam logic [31:0] TCC_MODE_WMASK = 32'h000F_C7FF;
    localparam logic [31:0] TCC_MODE_RESET = 32'h0000_0000;
    // first clock source code that picks an external clock
    localparam logic [2:0] TCC_CLKS_EXT0 = 3'h5;
    localparam int TCC_INT_CLKS = 5;
    localparam int TCC_EXT_CLKS = 3;

    // edge selection shared by trigger and both load fields
    typedef enum logic [1:0] {
        TCC_EDGE_NONE = 2'h0,
        TCC_EDGE_RISE = 2'h1,
        TCC_EDGE_FALL = 2'h2,
        TCC_EDGE_BOTH = 2'h3
    } tcc_edge_e;

    // bus slave states
    typedef enum logic [1:0] {
        TCC_BUS_IDLE = 2'h0,
        TCC_BUS_WR = 2'h1,
        TCC_BUS_RD = 2'h2,
        TCC_BUS_RDATA = 2'h3
    } tcc_bus_e;

    // mode register layout, msb first
    typedef struct packed {
        logic [11:0] rsvd_hi;
        tcc_edge_e b_load_edge_select;
        tcc_edge_e a_load_edge_select;
        logic wave_mode;
        logic compare_c_trig_enable;
        logic [2:0] rsvd_mid;
        logic trig_line_select;
        tcc_edge_e trig_edge_select;
        logic disable_on_b_load;
        logic stop_on_b_load;
        logic [1:0] clock_gate_select;
        logic count_edge_invert;
        logic [2:0] clock_source_select;
    } tcc_mode_s;

    // synchronised line edges
    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
    } tcc_line_s;
endpackage

// >>> sim/tcc_line_model.sv
// far-side model: clock sources and io lines that feed the timer channel
module tcc_line_model
(
    // clock
    input wire logic hclk,
    // io lines and clock sources
    output logic io_line_a,
    output logic io_line_b,
    output logic [tcc_pkg::TCC_INT_CLKS-1:0] internal_clock,
    output logic [tcc_pkg::TCC_EXT_CLKS-1:0] ext_clock
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [5:0] div = 6'h00;

    // free-running dividers, every one slower than half of hclk
    always @(posedge hclk)
        div <= div + 6'h01;
    assign internal_clock = div[5:1];

    // lines rest low until a scenario moves them
    initial
    begin
        io_line_a = 1'b0;
        io_line_b = 1'b0;
        ext_clock = 3'h0;
    end

    // k 0..2 external clocks, 3 line a, 4 line b
    task automatic level(input int k, input logic v);
        @(posedge hclk);
        if (k == 3)
            io_line_a <= v;
        else if (k == 4)
            io_line_b <= v;
        else
            ext_clock[k] <= v;
        // held past the two-flop synchroniser and edge flop
        repeat (6) @(posedge hclk);
    endtask

    // n whole pulses, rise then fall
    task automatic pulse(input int k, input int n);
        repeat (n)
        begin
            level(k, 1'b1);
            level(k, 1'b0);
        end
    endtask
endmodule // tcc_line_model

// >>> sim/timer_channel_capture_mode_tb_top.sv
// self-checking bench for the capture-mode timer channel
module timer_channel_capture_mode_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] A_CTRL = tcc_pkg::TCC_OFS_CTRL;
    localparam logic [7:0] A_MODE = tcc_pkg::TCC_OFS_MODE;
    localparam logic [7:0] A_CNT = tcc_pkg::TCC_OFS_COUNT;
    localparam logic [7:0] A_CAPA = tcc_pkg::TCC_OFS_CAP_A;
    localparam logic [7:0] A_CAPB = tcc_pkg::TCC_OFS_CAP_B;
    localparam logic [7:0] A_CMPC = tcc_pkg::TCC_OFS_CMP_C;
    localparam logic [7:0] A_STAT = tcc_pkg::TCC_OFS_STATUS;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic io_line_a;
    logic io_line_b;
    logic [tcc_pkg::TCC_INT_CLKS-1:0] internal_clock;
    logic [tcc_pkg::TCC_EXT_CLKS-1:0] ext_clock;
    int mismatches = 0;
    int num_checks = 0;

    tcc_capture #(.CNT_W(16)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .io_line_a(io_line_a),
        .io_line_b(io_line_b), .internal_clock(internal_clock), .ext_clock(ext_clock));
    tcc_line_model m (.hclk(hclk), .io_line_a(io_line_a), .io_line_b(io_line_b),
        .internal_clock(internal_clock), .ext_clock(ext_clock));

    // 200 mhz bus clock
    initial
    begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    task automatic stop_test();
        $display("mismatches=%0d num_checks=%0d", mismatches, num_checks);
        if (mismatches == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // ready is looked at just before the edge that samples it; bounded wait
    task automatic rdy(output logic [31:0] rd);
        int n;
        n = 0;
        do
        begin
            @(negedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        rd = hrdata;
        if (n >= 50)
        begin
            mismatches++;
            stop_test();
        end
    endtask

    // one single-word transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'h2;
        rdy(rd);
        @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        rdy(rd);
        @(posedge hclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(x, e);
        chk({31'h0, hresp}, 32'h0);
    endtask

    task automatic rs(input logic [31:0] msk, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, A_STAT, 32'h0, x);
        chk(x & msk, e);
    endtask

    // program the mode, then enable and trigger so the count starts at zero
    task automatic setup(input logic [31:0] md);
        wr(A_MODE, md);
        wr(A_CTRL, 32'h5);
    endtask

    task automatic t_reset();
        rc(A_MODE, tcc_pkg::TCC_MODE_RESET);
        rc(A_CNT, 32'h0);
        rc(A_CAPB, 32'h0);
        rc(A_STAT, 32'h0);
        wr(8'h08, 32'hFFFFFFFF);
        rc(8'h08, 32'h0);
        wr(A_MODE, 32'hFFFFFFFF);
        rc(A_MODE, tcc_pkg::TCC_MODE_WMASK);
        wr(A_CTRL, 32'h3);
        rs(32'h1, 32'h0);
        wr(A_CTRL, 32'h1);
        rs(32'h1, 32'h1);
        wr(A_CTRL, 32'h2);
        rs(32'h1, 32'h0);
    endtask

    // every source code; other external clocks must not count
    task automatic t_src();
        logic [31:0] x;
        for (int c = 0; c < 8; c++)
        begin
            setup(c);
            if (c < 5)
            begin
                repeat (80) @(posedge hclk);
                bus(1'b0, A_CNT, 32'h0, x);
                chk({31'h0, x != 32'h0}, 32'h1);
            end
            else
            begin
                m.pulse(c - 5, 3);
                m.pulse((c - 4) % 3, 2);
                rc(A_CNT, 32'h3);
            end
        end
        setup(32'h0D);
        m.level(0, 1'b1);
        rc(A_CNT, 32'h0);
        m.level(0, 1'b0);
        rc(A_CNT, 32'h1);
    endtask

    task automatic t_gate();
        for (int g = 2; g < 4; g++)
        begin
            setup(32'h5 | (g << 4));
            m.pulse(0, 2);
            rc(A_CNT, 32'h0);
            m.level(g - 1, 1'b1);
            m.pulse(0, 2);
            rc(A_CNT, 32'h2);
            m.level(g - 1, 1'b0);
        end
    endtask

    // loads come from line a only; line b moves must not load
    task automatic t_cap();
        setup(32'h0009_0005);
        m.pulse(0, 2);
        m.level(3, 1'b1);
        rc(A_CAPA, 32'h2);
        m.pulse(0, 3);
        m.level(4, 1'b1);
        m.level(4, 1'b0);
        rc(A_CAPB, 32'h0);
        m.level(3, 1'b0);
        rc(A_CAPB, 32'h5);
        rc(A_CAPA, 32'h2);
        wr(A_CAPA, 32'h1234);
        rc(A_CAPA, 32'h2);
        wr(A_CAPB, 32'h4321);
        rc(A_CAPB, 32'h5);
        // a on falling edges only, b on every edge of line a
        setup(32'h000E_0005);
        m.pulse(0, 2);
        m.level(3, 1'b1);
        rc(A_CAPB, 32'h2);
        m.pulse(0, 1);
        m.level(3, 1'b0);
        rc(A_CAPA, 32'h3);
        rc(A_CAPB, 32'h3);
    endtask

    task automatic t_stop();
        setup(32'h0004_0045);
        m.pulse(0, 2);
        m.level(3, 1'b1);
        rs(32'hF, 32'h5);
        m.pulse(0, 2);
        rc(A_CNT, 32'h2);
        m.level(3, 1'b0);
        setup(32'h0004_0085);
        m.level(3, 1'b1);
        rs(32'h1, 32'h0);
        m.level(3, 1'b0);
        setup(32'h0004_0005);
        m.level(3, 1'b1);
        m.pulse(0, 1);
        rc(A_CNT, 32'h1);
        m.level(3, 1'b0);
    endtask

    // all trigger edge codes on both lines; the other line is moved first
    task automatic t_trig();
        for (int e = 0; e < 4; e++)
            for (int s = 0; s < 2; s++)
            begin
                setup(32'h5 | (e << 8) | (s << 10));
                m.pulse(0, 3);
                m.pulse(3 + s, 1);
                m.level(4 - s, 1'b1);
                rc(A_CNT, e[0] ? 32'h0 : 32'h3);
                m.pulse(0, 1);
                m.level(4 - s, 1'b0);
                rc(A_CNT, e[1] ? 32'h0 : (e[0] ? 32'h1 : 32'h4));
            end
    endtask

    task automatic t_cmp_wave();
        wr(A_CMPC, 32'h3);
        setup(32'h0000_4005);
        m.pulse(0, 5);
        rc(A_CNT, 32'h1);
        setup(32'h5);
        m.pulse(0, 5);
        rc(A_CNT, 32'h5);
        setup(32'h0001_8105);
        wr(A_CAPA, 32'h55AA);
        rc(A_CAPA, 32'h55AA);
        m.pulse(0, 2);
        m.level(3, 1'b1);
        m.level(4, 1'b1);
        rc(A_CAPA, 32'h55AA);
        rc(A_CNT, 32'h2);
        m.level(3, 1'b0);
        m.level(4, 1'b0);
    endtask

    // main sequence
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_src();
        t_gate();
        t_cap();
        t_stop();
        t_trig();
        t_cmp_wave();
        stop_test();
    end
endmodule // timer_channel_capture_mode_tb_top

// >>> verilog/tcc_capture.sv
// timer channel in capture mode behind an ahb-lite slave
// Function
// - the three-bit clock source field picks one of five internal or three external clocks.
// - the count edge invert bit makes the counter advance on falling instead of rising edges.
// - the gate field ands the chosen clock with none or one of the three external clocks.
// - with stop on b load set, loading capture b stops the counter clock.
// - with disable on b load set, loading capture b disables the counter clock.
// - the trigger edge field picks none, rising, falling or both edges of the trigger line.
// - the trigger line bit picks line b when 0 and line a when 1.
// - with compare c trigger set, a match on compare c resets the counter and starts its clock.
// - the wave mode bit at 0 selects capture, at 1 turns capture off.
// - the a load field picks which edge of line a copies the counter into capture a.
// - the b load field picks which edge of line a copies the counter into capture b.
// - a software trigger command resets the counter and starts its clock.
// - the enable command enables the clock unless disable is set in the same write.
// - capture a and b are read-only while capture is selected, read/write otherwise.
module tcc_capture
#(
    parameter int CNT_W = 16
)
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // timer lines and clock sources
    input wire logic io_line_a,
    input wire logic io_line_b,
    input wire logic [tcc_pkg::TCC_INT_CLKS-1:0] internal_clock,
    input wire logic [tcc_pkg::TCC_EXT_CLKS-1:0] ext_clock
);
    tcc_pkg::tcc_bus_e state;
    tcc_pkg::tcc_bus_e next_state;
    logic [tcc_pkg::TCC_AW-1:0] addr;
    logic [tcc_pkg::TCC_AW-1:0] next_addr;
    logic [31:0] next_hrdata;
    logic accept;
    logic wr_go;
    tcc_pkg::tcc_mode_s mode;
    tcc_pkg::tcc_mode_s next_mode;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic [CNT_W-1:0] cap_a;
    logic [CNT_W-1:0] next_cap_a;
    logic [CNT_W-1:0] cap_b;
    logic [CNT_W-1:0] next_cap_b;
    logic [CNT_W-1:0] cmp_c;
    logic [CNT_W-1:0] next_cmp_c;
    logic clk_en;
    logic next_clk_en;
    logic clk_run;
    logic next_clk_run;
    tcc_pkg::tcc_line_s lines [2];
    logic [1:0] line_raw;
    logic tick;
    logic counting;
    logic capture_mode;
    logic cmd_on;
    logic cmd_off;
    logic cmd_trig;
    logic ext_trig;
    logic rc_trig;
    logic trigger;
    logic a_load;
    logic b_load;
    tcc_pkg::tcc_line_s trig_line;

    // line a at index 0, line b at index 1
    assign line_raw = {io_line_b, io_line_a};
    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_line
            tcc_line_sync u_sync
            (
                .hclk(hclk),
                .hresetn(hresetn),
                .line_in(line_raw[i]),
                .line_out(lines[i])
            );
        end
    endgenerate

    tcc_clk_sel u_clk
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .internal_clock(internal_clock),
        .ext_clock(ext_clock),
        .clock_source_select(mode.clock_source_select),
        .clock_gate_select(mode.clock_gate_select),
        .count_edge_invert(mode.count_edge_invert),
        .tick(tick)
    );

    // edge filter against a two-bit selection
    function automatic logic edge_hit(tcc_pkg::tcc_edge_e sel, tcc_pkg::tcc_line_s ln);
        logic hit;
        hit = 1'b0;
        case (sel)
            tcc_pkg::TCC_EDGE_RISE: hit = ln.rise;
            tcc_pkg::TCC_EDGE_FALL: hit = ln.fall;
            tcc_pkg::TCC_EDGE_BOTH: hit = ln.rise | ln.fall;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // bus: writes take no wait, reads take one so read data comes from a flop
    assign accept = hsel & htrans[1] & hready;
    assign wr_go = (state == tcc_pkg::TCC_BUS_WR);
    assign hreadyout = (state != tcc_pkg::TCC_BUS_RD);
    assign hresp = 1'b0;

    always_comb
    begin
        next_state = state;
        next_addr = addr;
        next_hrdata = hrdata;
        case (state)
            tcc_pkg::TCC_BUS_RD:
            begin
                next_state = tcc_pkg::TCC_BUS_RDATA;
                next_hrdata = 32'h0000_0000; // unmapped reads return zero
                if (addr == tcc_pkg::TCC_OFS_MODE)
                    next_hrdata = mode;
                else if (addr == tcc_pkg::TCC_OFS_COUNT)
                    next_hrdata = 32'(count);
                else if (addr == tcc_pkg::TCC_OFS_CAP_A)
                    next_hrdata = 32'(cap_a);
                else if (addr == tcc_pkg::TCC_OFS_CAP_B)
                    next_hrdata = 32'(cap_b);
                else if (addr == tcc_pkg::TCC_OFS_CMP_C)
                    next_hrdata = 32'(cmp_c);
                else if (addr == tcc_pkg::TCC_OFS_STATUS)
                    next_hrdata = 32'({lines[1].level, lines[0].level, clk_run, clk_en});
            end
            default:
            begin
                if (accept)
                begin
                    next_state = hwrite ? tcc_pkg::TCC_BUS_WR : tcc_pkg::TCC_BUS_RD;
                    next_addr = haddr[tcc_pkg::TCC_AW-1:0];
                end
                else
                    next_state = tcc_pkg::TCC_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= tcc_pkg::TCC_BUS_IDLE;
            addr <= '0;
            hrdata <= 32'h0000_0000;
        end
        else
        begin
            state <= next_state;
            addr <= next_addr;
            hrdata <= next_hrdata;
        end
    end

    // channel events
    always_comb
    begin
        capture_mode = ~mode.wave_mode;
        counting = clk_en & clk_run & tick;
        cmd_on = wr_go && addr == tcc_pkg::TCC_OFS_CTRL && hwdata[tcc_pkg::TCC_CMD_ON];
        cmd_off = wr_go && addr == tcc_pkg::TCC_OFS_CTRL && hwdata[tcc_pkg::TCC_CMD_OFF];
        cmd_trig = wr_go && addr == tcc_pkg::TCC_OFS_CTRL && hwdata[tcc_pkg::TCC_CMD_TRIG];
        trig_line = mode.trig_line_select ? lines[0] : lines[1];
        ext_trig = capture_mode & edge_hit(mode.trig_edge_select, trig_line);
        rc_trig = mode.compare_c_trig_enable & counting & (count == cmp_c);
        trigger = cmd_trig | ext_trig | rc_trig;
        a_load = capture_mode & edge_hit(mode.a_load_edge_select, lines[0]);
        b_load = capture_mode & edge_hit(mode.b_load_edge_select, lines[0]);
    end

    // channel state; trigger beats a stop in the same cycle
    always_comb
    begin
        next_mode = mode;
        next_count = count;
        next_cap_a = cap_a;
        next_cap_b = cap_b;
        next_cmp_c = cmp_c;
        next_clk_en = clk_en;
        next_clk_run = clk_run;
        if (wr_go && addr == tcc_pkg::TCC_OFS_MODE)
            next_mode = tcc_pkg::tcc_mode_s'(hwdata & tcc_pkg::TCC_MODE_WMASK);
        if (wr_go && addr == tcc_pkg::TCC_OFS_CMP_C)
            next_cmp_c = hwdata[CNT_W-1:0];
        // software may write the captures only outside capture operation
        if (wr_go && addr == tcc_pkg::TCC_OFS_CAP_A && !capture_mode)
            next_cap_a = hwdata[CNT_W-1:0];
        if (wr_go && addr == tcc_pkg::TCC_OFS_CAP_B && !capture_mode)
            next_cap_b = hwdata[CNT_W-1:0];
        if (a_load)
            next_cap_a = count;
        if (b_load)
            next_cap_b = count;
        if (counting)
            next_count = count + CNT_W'(1);
        if (b_load && mode.stop_on_b_load)
            next_clk_run = 1'b0;
        if (b_load && mode.disable_on_b_load)
            next_clk_en = 1'b0;
        if (cmd_on)
        begin
            next_clk_en = 1'b1;
            next_clk_run = 1'b1;
        end
        if (cmd_off)
            next_clk_en = 1'b0;
        if (trigger)
        begin
            next_count = '0;
            next_clk_run = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mode <= tcc_pkg::tcc_mode_s'(tcc_pkg::TCC_MODE_RESET);
            count <= '0;
            cap_a <= '0;
            cap_b <= '0;
            cmp_c <= '0;
            clk_en <= 1'b0;
            clk_run <= 1'b0;
        end
        else
        begin
            mode <= next_mode;
            count <= next_count;
            cap_a <= next_cap_a;
            cap_b <= next_cap_b;
            cmp_c <= next_cmp_c;
            clk_en <= next_clk_en;
            clk_run <= next_clk_run;
        end
    end

    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_swtrig_reset: assert property (cmd_trig |=> count == '0 && clk_run)
        else $error("software trigger did not reset the counter");
    chk_off_wins: assert property (cmd_off |=> !clk_en)
        else $error("disable command did not disable the clock");
    chk_on_enables: assert property (cmd_on && !cmd_off |=> clk_en)
        else $error("enable command did not enable the clock");
    chk_a_capture: assert property (a_load |=> cap_a == $past(count))
        else $error("capture a did not take the counter value");
    chk_b_capture: assert property (b_load |=> cap_b == $past(count))
        else $error("capture b did not take the counter value");
    chk_b_stop: assert property (
        b_load && mode.stop_on_b_load && !trigger && !cmd_on |=> !clk_run)
        else $error("clock kept running after b load with stop set");
    chk_b_disable: assert property (
        b_load && mode.disable_on_b_load && !cmd_on |=> !clk_en)
        else $error("clock stayed enabled after b load with disable set");
    chk_rc_trigger: assert property (rc_trig |=> count == '0 ##0 clk_run)
        else $error("compare c match did not restart the counter");
    chk_ext_trigger: assert property (ext_trig |=> count == '0 && clk_run)
        else $error("external trigger did not restart the counter");
    chk_wave_quiet: assert property (mode.wave_mode |-> !a_load && !b_load && !ext_trig)
        else $error("capture event seen in waveform mode");
    chk_a_readonly: assert property (capture_mode && !a_load |=> cap_a == $past(cap_a))
        else $error("capture a changed by software in capture mode");
    chk_b_readonly: assert property (capture_mode && !b_load |=> cap_b == $past(cap_b))
        else $error("capture b changed by software in capture mode");
    // in waveform mode only a software write may move capture a, never a line edge
    chk_wave_hold: assert property (
        mode.wave_mode && !(wr_go && addr == tcc_pkg::TCC_OFS_CAP_A) |=> cap_a == $past(cap_a))
        else $error("capture a loaded by a line edge in waveform mode");
    chk_single_edge: assert property (lines[0].rise |=> !lines[0].rise)
        else $error("one edge of line a gave two events");
    chk_count_step: assert property (counting && !trigger |=> count == $past(count) + CNT_W'(1))
        else $error("counter did not step by one on a counting edge");

    cov_a_then_b: cover property (a_load ##[1:50] b_load);
    cov_rc_trig: cover property (rc_trig);
    cov_ext_trig: cover property (ext_trig ##1 counting);
    cov_read: cover property (state == tcc_pkg::TCC_BUS_RD ##1 hreadyout);
    cov_b_stop: cover property (b_load && mode.stop_on_b_load);
endmodule // tcc_capture

// >>> verilog/tcc_clk_sel.sv
// counter clock selection, gating and count-edge detection
module tcc_clk_sel
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // clock sources, sampled on hclk
    input wire logic [tcc_pkg::TCC_INT_CLKS-1:0] internal_clock,
    input wire logic [tcc_pkg::TCC_EXT_CLKS-1:0] ext_clock,
    // mode fields
    input wire logic [2:0] clock_source_select,
    input wire logic [1:0] clock_gate_select,
    input wire logic count_edge_invert,
    // one pulse per counting edge
    output logic tick
);
    logic sel_clk;
    logic gated;
    logic last;
    logic next_last;

    // source pick and optional and-gate with an external clock
    always_comb
    begin
        if (clock_source_select < tcc_pkg::TCC_CLKS_EXT0)
            sel_clk = internal_clock[clock_source_select];
        else
            sel_clk = ext_clock[2'(clock_source_select - tcc_pkg::TCC_CLKS_EXT0)];
        if (clock_gate_select == 2'h0)
            gated = sel_clk;
        else
            gated = sel_clk & ext_clock[2'(clock_gate_select - 2'h1)];
        next_last = gated;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            last <= 1'b0;
        else
            last <= next_last;
    end

    // rising edge by default, falling when inverted
    assign tick = count_edge_invert ? (last & ~gated) : (~last & gated);
endmodule // tcc_clk_sel

// >>> verilog/tcc_line_sync.sv
// two-flop synchroniser and edge detector for one timer io line
module tcc_line_sync
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // line
    input wire logic line_in,
    output tcc_pkg::tcc_line_s line_out
);
    logic meta;
    logic sync;
    logic prev;
    logic next_meta;
    logic next_sync;
    logic next_prev;

    // shift chain; meta is read only by sync
    always_comb
    begin
        next_meta = line_in;
        next_sync = meta;
        next_prev = sync;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end
        else
        begin
            meta <= next_meta;
            sync <= next_sync;
            prev <= next_prev;
        end
    end

    // one pulse per settled edge
    assign line_out.level = sync;
    assign line_out.rise = sync & ~prev;
    assign line_out.fall = ~sync & prev;
endmodule // tcc_line_sync
